// ==== sbp_fifo.sv ====
/*
 * sbp_fifo: synchronous valid/ready FIFO, width and depth parameters.
 * assumes: single clock, depth a power of two, clock enable freezes it.
 */
`timescale 1ns/1ps
`default_nettype none
module sbp_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic en_i,
    input wire logic [WIDTH-1:0] in_data_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    output logic [WIDTH-1:0] out_data_o,
    output logic out_valid_o,
    input wire logic out_ready_i
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW:0] wr_q, wr_d, rd_q, rd_d;
    logic push, pop, full, empty;

    always_comb begin
        empty = (wr_q == rd_q);
        full = (wr_q[AW-1:0] == rd_q[AW-1:0]) && (wr_q[AW] != rd_q[AW]);
        push = in_valid_i && !full;
        pop = out_ready_i && !empty;
        wr_d = push ? wr_q + 1'b1 : wr_q;
        rd_d = pop ? rd_q + 1'b1 : rd_q;
        in_ready_o = !full;
        out_valid_o = !empty;
        out_data_o = mem_q[rd_q[AW-1:0]];
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            wr_q <= '0;
            rd_q <= '0;
        end else if (en_i) begin
            wr_q <= wr_d;
            rd_q <= rd_d;
        end
    end

    // storage has no reset; contents are only read once written
    always_ff @(posedge clk_i) begin
        if (en_i && push) begin
            mem_q[wr_q[AW-1:0]] <= in_data_i;
        end
    end
endmodule // sbp_fifo
`default_nettype wire

// ==== sbp_peer.sv ====
/* sbp_peer: external logic, offers a new byte once a read strobe
   pulse has ended. assumes active low strobe, one clock. */
`timescale 1ns/1ps
`default_nettype none
module sbp_peer (
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic rd_strobe_b_i,
    output logic [7:0] port_in_o
);
    logic low_q;
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            low_q <= 1'b0;
            port_in_o <= 8'h5a;
        end else begin
            low_q <= !rd_strobe_b_i;
            if (low_q && rd_strobe_b_i) port_in_o <= port_in_o + 8'h3b;
        end
    end
endmodule // sbp_peer
`default_nettype wire

// ==== sbp_pkg.sv ====
/*
 * sbp_pkg: constants and types shared by the strobed byte port design.
 * assumes: one clock domain, counts expressed in processor output clocks.
 */
package sbp_pkg;
    localparam int SBP_DATA_W = 8;
    localparam int SBP_FIFO_DEPTH = 8;
    // cycle counts of the strobe sequence, in processor output clocks
    localparam int SBP_WR_DELAY_CYC = 2;
    localparam int SBP_RD_DELAY_CYC = 3;
    localparam int SBP_STROBE_CYC = 2;
    localparam int SBP_CNT_W = 3;
    localparam logic [SBP_DATA_W-1:0] SBP_PORT_RST = 8'h00;
    localparam logic SBP_STROBE_IDLE = 1'b1;
    typedef enum logic [2:0] {
        SBP_IDLE,
        SBP_WR_WAIT,
        SBP_WR_PULSE,
        SBP_RD_WAIT,
        SBP_RD_PULSE
    } sbp_state_t;
endpackage : sbp_pkg

// ==== sbp_port.sv ====
/*
 * sbp_port: 8-bit general purpose port with read and write handshake
 * strobes pulsed on processor accesses while strobing is enabled.
 * Processor writes pass through a FIFO; a write waits for the
 * previous strobe sequence to finish.
 * assumes: processor request pulses are on clk_i (the processor output
 * clock); port pins and enable come from outside and are synchronised.
 * rd_req_i is a one-cycle pulse; a read arriving while a strobe
 * sequence runs is dropped and gets no rd_valid_o.
 * with strobing off, accesses still move data but both strobes stay
 * high. port_oe_o is high from the first clock after reset, since
 * there is no direction control.
 * write: output changes at the pop edge, write strobe low two edges
 * later for two cycles.
 * read: input latched at the request edge, read strobe low three
 * edges later for two cycles; the peer may move its byte after that.
 * the fifo soaks up bursts; wr_ready_o is low while it is full and
 * from reset until the first clock after reset.
 * limitation: a write stays queued while a read sequence runs.
 */
// Contract
// (RULE1) strobes pulse only while strobe enable set
// (RULE2) each strobe lasts exactly two cycles
// (RULE3) write strobe two cycles after output update
// (RULE4) read returns input latched three cycles earlier
// (RULE5) read strobe three cycles after read
// (RULE6) nothing sampled while read strobe asserted
// (RULE7) external byte stable until read strobe
// (RULE8) strobes active low, idle high otherwise
`timescale 1ns/1ps
`default_nettype none
module sbp_port
    import sbp_pkg::*;
#(
    parameter int FIFO_DEPTH = sbp_pkg::SBP_FIFO_DEPTH
) (
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic clk_en_i,
    input wire logic port_strobe_enable_i,
    input wire logic [sbp_pkg::SBP_DATA_W-1:0] wr_data_i,
    input wire logic wr_valid_i,
    output logic wr_ready_o,
    input wire logic rd_req_i,
    output logic [sbp_pkg::SBP_DATA_W-1:0] rd_data_o,
    output logic rd_valid_o,
    input wire logic [sbp_pkg::SBP_DATA_W-1:0] port_in_i,
    output logic [sbp_pkg::SBP_DATA_W-1:0] port_out_o,
    output logic port_oe_o,
    output logic rd_strobe_b_o,
    output logic wr_strobe_b_o
);
    import sbp_pkg::*;

    logic [SBP_DATA_W-1:0] fifo_data;
    logic fifo_valid, fifo_ready, fifo_in_ready;
    logic [SBP_DATA_W-1:0] pin_m_q, pin_s_q;
    logic ena_m_q, ena_s_q;
    // engine state and the down counter shared by every phase
    sbp_state_t state_q, state_d;
    logic [SBP_CNT_W-1:0] cnt_q, cnt_d;
    logic [SBP_DATA_W-1:0] out_q, out_d, rdat_q, rdat_d;
    logic rvld_q, rvld_d, rstb_q, rstb_d, wstb_q, wstb_d;
    localparam int FILL_W = $clog2(FIFO_DEPTH) + 1;
    logic wrdy_q, wrdy_d, oe_q, oe_d;
    logic [FILL_W-1:0] fill_q, fill_d;

    // fifo shares the clock enable, so a frozen block drops no byte
    sbp_fifo #(
        .WIDTH(SBP_DATA_W),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk_i(clk_i),
        .rst_b_i(rst_b_i),
        .en_i(clk_en_i),
        .in_data_i(wr_data_i),
        .in_valid_i(wr_valid_i),
        .in_ready_o(fifo_in_ready),
        .out_data_o(fifo_data),
        .out_valid_o(fifo_valid),
        .out_ready_i(fifo_ready)
    );

    // two flops on every pin input; only the second stage is read
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            pin_m_q <= SBP_PORT_RST;
            pin_s_q <= SBP_PORT_RST;
            ena_m_q <= 1'b0;
            ena_s_q <= 1'b0;
        end else if (clk_en_i) begin
            pin_m_q <= port_in_i;
            pin_s_q <= pin_m_q;
            ena_m_q <= port_strobe_enable_i;
            ena_s_q <= ena_m_q;
        end
    end

    // a read takes priority over a queued write when both are pending
    always_comb begin
        state_d = state_q;
        cnt_d = cnt_q;
        out_d = out_q;
        rdat_d = rdat_q;
        rvld_d = 1'b0;
        rstb_d = SBP_STROBE_IDLE; // RULE8
        wstb_d = SBP_STROBE_IDLE; // RULE8
        fifo_ready = 1'b0;
        oe_d = 1'b1;
        unique case (state_q)
            SBP_IDLE: begin
                if (rd_req_i) begin
                    // input captured now, never on the strobe itself
                    rdat_d = pin_s_q; // RULE4 RULE6
                    rvld_d = 1'b1;
                    if (ena_s_q) begin // RULE1
                        state_d = SBP_RD_WAIT;
                        cnt_d = SBP_CNT_W'(SBP_RD_DELAY_CYC - 1);
                    end
                end else if (fifo_valid) begin
                    // with strobing off the byte still goes out, unannounced
                    fifo_ready = 1'b1;
                    out_d = fifo_data;
                    if (ena_s_q) begin // RULE1
                        state_d = SBP_WR_WAIT;
                        cnt_d = SBP_CNT_W'(SBP_WR_DELAY_CYC - 1);
                    end
                end
            end
            SBP_WR_WAIT: begin
                // gap between the new output value and the strobe
                cnt_d = cnt_q - 1'b1;
                if (cnt_q == '0) begin
                    state_d = SBP_WR_PULSE; // RULE3
                    cnt_d = SBP_CNT_W'(SBP_STROBE_CYC - 1);
                    wstb_d = 1'b0;
                end
            end
            SBP_WR_PULSE: begin
                // second low cycle, released on the edge after
                cnt_d = cnt_q - 1'b1;
                if (cnt_q == '0) begin
                    state_d = SBP_IDLE;
                end else begin
                    wstb_d = 1'b0; // RULE2
                end
            end
            SBP_RD_WAIT: begin
                cnt_d = cnt_q - 1'b1;
                if (cnt_q == '0) begin
                    // strobe three edges after the request edge latched
                    state_d = SBP_RD_PULSE; // RULE5
                    cnt_d = SBP_CNT_W'(SBP_STROBE_CYC - 1);
                    rstb_d = 1'b0;
                end
            end
            SBP_RD_PULSE: begin
                // external side may change its byte from here on
                cnt_d = cnt_q - 1'b1;
                if (cnt_q == '0) begin
                    state_d = SBP_IDLE; // RULE7
                end else begin
                    rstb_d = 1'b0; // RULE2
                end
            end
        endcase
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            state_q <= SBP_IDLE;
            cnt_q <= '0;
            out_q <= SBP_PORT_RST;
            rdat_q <= SBP_PORT_RST;
            rvld_q <= 1'b0;
            rstb_q <= SBP_STROBE_IDLE;
            wstb_q <= SBP_STROBE_IDLE;
            oe_q <= 1'b0;
        end else if (clk_en_i) begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            out_q <= out_d;
            rdat_q <= rdat_d;
            rvld_q <= rvld_d;
            rstb_q <= rstb_d;
            wstb_q <= wstb_d;
            oe_q <= oe_d;
        end
    end

    // ready leaves a flop, so it must predict the fill after this edge;
    // a copy of not-full would be one cycle stale and drop a byte
    always_comb begin
        fill_d = fill_q;
        if (wr_valid_i && fifo_in_ready) begin
            fill_d = fill_d + 1'b1;
        end
        if (fifo_ready && fifo_valid) begin
            fill_d = fill_d - 1'b1;
        end
        wrdy_d = (fill_d != FILL_W'(FIFO_DEPTH));
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            fill_q <= '0;
            wrdy_q <= 1'b0;
        end else if (clk_en_i) begin
            fill_q <= fill_d;
            wrdy_q <= wrdy_d;
        end
    end

    // outputs are bare copies of registers
    always_comb begin
        port_out_o = out_q;
        port_oe_o = oe_q;
        rd_data_o = rdat_q;
        rd_valid_o = rvld_q;
        rd_strobe_b_o = rstb_q;
        wr_strobe_b_o = wstb_q;
        wr_ready_o = wrdy_q;
    end
endmodule // sbp_port
`default_nettype wire

// ==== sbp_port_properties.sv ====
/* sbp_port_properties: strobe checks bound to sbp_port.
   assumes clk_en_i held high. */
`timescale 1ns/1ps
`default_nettype none
module sbp_port_properties (
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic port_strobe_enable_i,
    input wire logic rd_valid_o,
    input wire logic [7:0] rd_data_o,
    input wire logic [7:0] port_out_o,
    input wire logic rd_strobe_b_o,
    input wire logic wr_strobe_b_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);
    wr_width_a: assert property ($fell(wr_strobe_b_o) |=>
        !wr_strobe_b_o ##1 wr_strobe_b_o) else $error("wr width");
    rd_width_a: assert property ($fell(rd_strobe_b_o) |=>
        !rd_strobe_b_o ##1 rd_strobe_b_o) else $error("rd width");
    rd_delay_a: assert property ($fell(rd_strobe_b_o) |->
        $past(rd_valid_o, 3)) else $error("rd delay");
    valid_pulse_a: assert property (rd_valid_o &&
        $past(port_strobe_enable_i, 3) |=> !rd_valid_o)
        else $error("rd valid");
    rd_hold_a: assert property (!rd_valid_o |->
        $stable(rd_data_o)) else $error("rd data moved");
    wr_hold_a: assert property (!wr_strobe_b_o |->
        $stable(port_out_o)) else $error("out moved");
    off_idle_a: assert property ((!port_strobe_enable_i)[*8] |->
        rd_strobe_b_o && wr_strobe_b_o) else $error("strobe off");
    one_strobe_a: assert property (rd_strobe_b_o ||
        wr_strobe_b_o) else $error("both strobes");
endmodule // sbp_port_properties
bind sbp_port sbp_port_properties u_props (.clk_i, .rst_b_i,
    .port_strobe_enable_i, .rd_valid_o, .rd_data_o, .port_out_o,
    .rd_strobe_b_o, .wr_strobe_b_o);
`default_nettype wire

// ==== sbp_port_tb.sv ====
/* sbp_port_tb: writes and reads through sbp_port, sbp_peer on pins.
   assumes clock enable tied high. */
`timescale 1ns/1ps
`default_nettype none
module sbp_port_tb;
    logic clk, rst_b, en, wv, wrdy, rq, rv, ws, rs, oe;
    logic [7:0] wd, rdat, pin, pout, d;
    logic [7:0] wq[$];
    int num_errors = 0, n_compared = 0, c, i, st = 0;
    sbp_port u_dut (.clk_i(clk), .rst_b_i(rst_b), .clk_en_i(1'b1),
        .port_strobe_enable_i(en), .wr_data_i(wd), .wr_valid_i(wv),
        .wr_ready_o(wrdy), .rd_req_i(rq), .rd_data_o(rdat),
        .rd_valid_o(rv), .port_in_i(pin), .port_out_o(pout),
        .port_oe_o(oe), .rd_strobe_b_o(rs), .wr_strobe_b_o(ws));
    sbp_peer u_peer (.clk_i(clk), .rst_b_i(rst_b), .rd_strobe_b_i(rs),
        .port_in_o(pin));
    initial begin
        clk = 0;
        forever #5 clk = ~clk;
    end
    task automatic cmp(string s, logic [7:0] e, logic [7:0] g);
        n_compared++;
        if (g !== e) begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", s, e, g);
        end
    endtask
    task automatic conclude;
        $display("errors %0d compares %0d", num_errors, n_compared);
        if (num_errors == 0 && n_compared > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    // negedges until a strobe falls, 15 if none
    task automatic gap(bit r);
        for (c = 0; c < 15 && (r ? rs : ws) !== 1'b0; c++) @(negedge clk);
    endtask
    // valid stays up so back-to-back writes never toggle it
    task automatic wr(logic [7:0] v);
        wd = v;
        wv = 1;
        for (c = 0; wrdy !== 1'b1; c++) begin
            if (c > 60) begin
                num_errors++;
                conclude();
            end
            @(negedge clk);
        end
        if (c > 0) st++;
        if (en) wq.push_back(v);
        @(negedge clk);
    endtask
    task automatic rd;
        d = pin;
        rq = 1;
        @(negedge clk);
        rq = 0;
        // valid stands one cycle: look right after the request edge
        cmp("rd valid", 8'h01, {7'h0, rv});
        cmp("rd data", d, rdat);
        gap(1);
    endtask
    always @(negedge ws) begin
        if (wq.size() > 0) cmp("wr byte", wq.pop_front(), pout);
        else cmp("wr strobe", 8'h00, 8'hff);
    end
    initial begin
        {rst_b, en, wv, rq, wd} = '0;
        void'($urandom(56));
        repeat (10) @(negedge clk);
        cmp("reset strobes", 8'h03, {6'h0, rs, ws});
        cmp("reset oe", 8'h00, {7'h0, oe});
        rst_b = 1;
        en = 1;
        repeat (4) @(negedge clk);
        cmp("idle strobes", 8'h03, {6'h0, rs, ws});
        cmp("run oe", 8'h01, {7'h0, oe});
        for (i = 0; i < 8; i++) begin
            wr(i == 0 ? 8'h00 : i == 1 ? 8'hff : 8'($urandom));
            wv = 0;
            gap(0);
            cmp("wr delay", en ? 8'h03 : 8'h0f, 8'(c));
            // engine back in idle by now: the read is served
            repeat (3) @(negedge clk);
            rd();
            cmp("rd delay", en ? 8'h03 : 8'h0f, 8'(c));
            if (i == 5) en = 0;
            repeat (10) @(negedge clk);
        end
        en = 1;
        repeat (4) @(negedge clk);
        for (i = 0; i < 12; i++) wr(8'($urandom));
        wv = 0;
        cmp("fifo full", 8'h01, 8'(st > 0));
        for (c = 0; c < 300 && wq.size() > 0; c++) @(negedge clk);
        cmp("fifo drained", 8'h00, 8'(wq.size()));
        conclude();
    end
endmodule // sbp_port_tb
`default_nettype wire
